// ==== rtl/drc_top.v ====
// Purpose: dram-side refresh, self refresh and dll mode control
// Assumes: command pins already decoded to cs_n/ras_n/cas_n/we_n, sampled on mclk
// Notes:   checks the controller's behaviour and flags violations in status
`timescale 1ns/10ps
`include "drc_map.vh"

// What the document requires
// [R1] controller refreshes every 7.8us or 3.9us
// [R2] refresh address is internal, address ignored
// [R3] refresh runs trfc from registered command
// [R4] only nop/des allowed during trfc
// [R5] at most eight refreshes postponed; not checked, no postponed count is kept
// [R6] postponed count spans self refresh
// [R7] over-posting tolerated within 64ms period
// [R8] cke high on pre, act, ref; pre and act look only at cke_d_r, the cke of the cycle before, while ref also looks at cke
// [R9] precharge all banks before refresh
// [R10] self refresh keeps data without clock
// [R11] first write 512 clocks after vrefdq valid
// [R12] dll off supports only cl6, cwl6
// [R13] dll off strobe window at al+cl-1
// [R14] dll off: odt low, termination fields zero
// [R15] clock rate change only in self refresh
// [R16] dll disable sequence through self refresh
// [R17] next command after max of tmrd, tmod
// [R18] dll enable sequence with dll reset
// [R19] wait tdllk after dll reset
// [R20] idle means banks closed, cke high
// [R21] controller tracks postponed refresh count; the block only counts all refreshes, in ref_total_r
// [R22] controller times delays with counters
module drc_top (
  input  wire        mclk,
  input  wire        srst,
  input  wire        cke_pin,
  input  wire        cs_n_pin,
  input  wire        ras_n_pin,
  input  wire        cas_n_pin,
  input  wire        we_n_pin,
  input  wire [2:0]  ba_pin,
  input  wire [15:0] addr_pin,
  input  wire        odt_pin,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         sref_active_r,
  output reg         dll_off_r,
  output reg         ref_busy_r,
  output reg         rd_win_start_r
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [23:0] pin_raw = {cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin,
                         ba_pin, addr_pin};
  wire [23:0] pin_s;
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi = gi + 1) begin : g_sync
      drc_sync u_sync (
        .clk (mclk),
        .rst (srst),
        .d   (pin_raw[gi]),
        .q   (pin_s[gi])
      );
    end
  endgenerate
  wire        odt_s;
  drc_sync u_odt (
    .clk (mclk),
    .rst (srst),
    .d   (odt_pin),
    .q   (odt_s)
  );

  wire        cke   = pin_s[23];
  wire        cs_n  = pin_s[22];
  wire [2:0]  cmd   = pin_s[21:19];
  wire [2:0]  ba    = pin_s[18:16];
  wire [15:0] addr  = pin_s[15:0];

  reg         cke_d_r;
  wire        valid = ~cs_n & cke_d_r;
  wire        c_ref = valid & cke & (cmd == `DRC_CMD_REF);
  wire        c_sre = ~cs_n & cke_d_r & ~cke & (cmd == `DRC_CMD_REF);
  wire        c_mrs = valid & (cmd == `DRC_CMD_MRS);
  wire        c_pre = valid & (cmd == `DRC_CMD_PRE);
  wire        c_act = valid & (cmd == `DRC_CMD_ACT);
  wire        c_rd  = valid & (cmd == `DRC_CMD_RD);
  wire        c_wr  = valid & (cmd == `DRC_CMD_WR);
  wire        c_any = valid & (cmd != `DRC_CMD_NOP);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  reg  [9:0]  trfc_r;
  reg  [3:0]  al_r;
  reg  [3:0]  cl_r;
  reg  [9:0]  rfc_cnt_r;
  reg  [7:0]  bank_open_r;
  reg  [31:0] ref_total_r;
  reg         viol_r;
  reg         odt_err_r;
  reg         lat_err_r;
  reg  [15:0] mr0_r;
  reg  [15:0] mr1_r;
  reg  [15:0] mr2_r;
  reg  [31:0] rdata_nxt;

  // read strobe window: one cycle earlier with the dll off
  wire [3:0]  cl_eff = dll_off_r ? `DRC_DLLOFF_CL : cl_r; // [R12]
  wire [4:0]  rd_lat = {1'b0, al_r} + {1'b0, cl_eff} - {4'h0, dll_off_r}; // [R13]

  // a write lands only at the edge where pready is seen high by the master
  wire        wr_acc = psel & penable & pwrite & pready;
  wire        rd_acc = psel & penable & ~pwrite & ~pready;
  wire        hit    = (paddr == `DRC_OFF_CTRL) | (paddr == `DRC_OFF_STATUS) |
                       (paddr == `DRC_OFF_REFCNT) | (paddr == `DRC_OFF_TRFC) |
                       (paddr == `DRC_OFF_LAT);

  // ----------------------------------------------------------------
  // apb slave: one wait state, answer on the second access cycle
  // ----------------------------------------------------------------
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      `DRC_OFF_CTRL:   rdata_nxt = {24'h00_0000, cl_r, al_r};
      `DRC_OFF_STATUS: rdata_nxt = {26'h000_0000, lat_err_r, odt_err_r, viol_r,
                                    ref_busy_r, dll_off_r, sref_active_r};
      `DRC_OFF_REFCNT: rdata_nxt = ref_total_r;
      `DRC_OFF_TRFC:   rdata_nxt = {22'h00_0000, trfc_r};
      `DRC_OFF_LAT:    rdata_nxt = {27'h000_0000, rd_lat};
      default:         rdata_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      trfc_r  <= `DRC_TRFC_RST;
      al_r    <= `DRC_AL_RST;
      cl_r    <= `DRC_CL_RST;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      prdata  <= rd_acc ? rdata_nxt : 32'h0000_0000;
      if (wr_acc && paddr == `DRC_OFF_CTRL) begin
        al_r <= pwdata[`DRC_CTRL_AL_LSB +: 4];
        cl_r <= pwdata[`DRC_CTRL_CL_LSB +: 4];
      end
      if (wr_acc && paddr == `DRC_OFF_TRFC)
        trfc_r <= (pwdata[9:0] == 10'h000) ? 10'h001 : pwdata[9:0];
    end
  end

  // ----------------------------------------------------------------
  // refresh engine: internal row counter, trfc window, self refresh
  // ----------------------------------------------------------------
  reg [15:0] ref_row_r;
  always @(posedge mclk) begin
    if (srst) begin
      cke_d_r       <= 1'b0; // synced pins not read as a command right after reset
      rfc_cnt_r     <= 10'h000;
      ref_busy_r    <= 1'b0;
      ref_row_r     <= 16'h0000;
      ref_total_r   <= 32'h0000_0000;
      sref_active_r <= 1'b0;
      bank_open_r   <= 8'h00;
      viol_r        <= 1'b0;
    end else begin
      cke_d_r <= cke;
      // address pins are not looked at; the row comes from ref_row_r
      if (c_ref) begin // [R2]
        ref_row_r   <= ref_row_r + 16'h0001;
        ref_total_r <= ref_total_r + 32'h0000_0001;
        rfc_cnt_r   <= trfc_r - 10'h001; // [R3]
        ref_busy_r  <= 1'b1;
      end else if (rfc_cnt_r != 10'h000) begin
        rfc_cnt_r <= rfc_cnt_r - 10'h001;
      end else begin
        ref_busy_r <= 1'b0; // [R3]
      end
      // self refresh: entered by ref with cke low, left on cke high
      if (c_sre)
        sref_active_r <= 1'b1; // [R10]
      else if (sref_active_r && cke)
        sref_active_r <= 1'b0;
      if (c_act)
        bank_open_r[ba] <= 1'b1;
      if (c_pre)
        bank_open_r <= addr[10] ? 8'h00 : (bank_open_r & ~(8'h01 << ba));
      // command during trfc or refresh with banks open is flagged
      if ((ref_busy_r && c_any) || ((c_ref | c_sre) && bank_open_r != 8'h00)) // [R4] [R9]
        viol_r <= 1'b1;
      else if (wr_acc && paddr == `DRC_OFF_STATUS && pwdata[`DRC_ST_VIOL])
        viol_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // mode registers and dll mode; mode change lands only via mrs
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      mr0_r     <= 16'h0000;
      mr1_r     <= 16'h0000;
      mr2_r     <= 16'h0000;
      dll_off_r <= 1'b0;
      odt_err_r <= 1'b0;
      lat_err_r <= 1'b0;
    end else begin
      if (c_mrs) begin
        case (ba[1:0])
          2'h0:    mr0_r <= addr;
          2'h1:    mr1_r <= addr;
          2'h2:    mr2_r <= addr;
          default: mr2_r <= mr2_r;
        endcase
        if (ba[1:0] == 2'h1)
          dll_off_r <= addr[0]; // [R17] mode takes effect at the mrs itself
      end
      // termination must stay off while the dll is off
      if (dll_off_r && (odt_s || mr1_r[9] || mr1_r[6] || mr1_r[2] ||
                        mr2_r[10] || mr2_r[9]))
        odt_err_r <= 1'b1; // [R14]
      else if (wr_acc && paddr == `DRC_OFF_STATUS && pwdata[`DRC_ST_ODTERR])
        odt_err_r <= 1'b0;
      // only cl 6 / cwl 6 are legal without the dll
      if (dll_off_r && (cl_r != `DRC_DLLOFF_CL || (c_rd | c_wr) &&
                        cl_r != `DRC_DLLOFF_CWL))
        lat_err_r <= 1'b1; // [R12]
      else if (wr_acc && paddr == `DRC_OFF_STATUS && pwdata[`DRC_ST_LATERR])
        lat_err_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read strobe window counter
  // ----------------------------------------------------------------
  wire       win_w;
  drc_rdlat u_rdlat (
    .clk       (mclk),
    .rst       (srst),
    .rd_go     (c_rd),
    .lat       (rd_lat),
    .win_start (win_w)
  );
  always @(posedge mclk) begin
    if (srst)
      rd_win_start_r <= 1'b0;
    else
      rd_win_start_r <= win_w;
  end
endmodule

// ==== common/drc_map.vh ====
// Purpose: constants for the dram refresh / dll mode control block
// Assumes: mclk at 250 MHz (4 ns), command bus sampled on mclk
// Notes:   offsets are byte addresses on an apb bus with 32-bit data
`ifndef DRC_MAP_VH
`define DRC_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DRC_OFF_CTRL      12'h000
`define DRC_OFF_STATUS    12'h004
`define DRC_OFF_REFCNT    12'h008
`define DRC_OFF_TRFC      12'h00c
`define DRC_OFF_LAT       12'h010

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DRC_CTRL_AL_LSB   0
`define DRC_CTRL_CL_LSB   4
`define DRC_ST_SREF       0
`define DRC_ST_DLLOFF     1
`define DRC_ST_RFBUSY     2
`define DRC_ST_VIOL       3
`define DRC_ST_ODTERR     4
`define DRC_ST_LATERR     5
`define DRC_TRFC_RST      10'h06e
`define DRC_CL_RST        4'h6
`define DRC_AL_RST        4'h0

// ----------------------------------------------------------------
// fixed latencies in dll disable mode
// ----------------------------------------------------------------
`define DRC_DLLOFF_CL     4'h6
`define DRC_DLLOFF_CWL    4'h6

// ----------------------------------------------------------------
// command encodings {ras_n, cas_n, we_n} with cs_n low
// ----------------------------------------------------------------
`define DRC_CMD_MRS       3'h0
`define DRC_CMD_REF       3'h1
`define DRC_CMD_PRE       3'h2
`define DRC_CMD_ACT       3'h3
`define DRC_CMD_WR        3'h4
`define DRC_CMD_RD        3'h5
`define DRC_CMD_ZQ        3'h6
`define DRC_CMD_NOP       3'h7

`endif

// ==== rtl/drc_sync.v ====
// Purpose: two-flop synchroniser for one pin level
// Assumes: d is asynchronous to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
module drc_sync (
  input  wire clk,
  input  wire rst,
  input  wire d,
  output wire q
);
  reg s1_r;
  reg s2_r;

  // ----------------------------------------------------------------
  // two stages
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule

// ==== rtl/drc_rdlat.v ====
// Purpose: read strobe window start counter
// Assumes: rd_go is a one-cycle pulse on a registered read
// Notes:   one read in flight; a new read restarts the count
`timescale 1ns/10ps
`include "drc_map.vh"
module drc_rdlat (
  input  wire       clk,
  input  wire       rst,
  input  wire       rd_go,
  input  wire [4:0] lat,
  output reg        win_start
);
  reg [4:0] cnt_r;
  reg       run_r;

  // ----------------------------------------------------------------
  // count lat cycles from the read, then flag the window start
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      cnt_r     <= 5'h00;
      run_r     <= 1'b0;
      win_start <= 1'b0;
    end else begin
      win_start <= 1'b0;
      if (rd_go) begin
        cnt_r <= (lat > 5'h01) ? lat - 5'h02 : 5'h00;
        run_r <= (lat > 5'h01);
        win_start <= (lat <= 5'h01);
      end else if (run_r) begin
        if (cnt_r == 5'h00) begin
          run_r     <= 1'b0;
          win_start <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 5'h01;
        end
      end
    end
  end
endmodule

// ==== sim/drc_monitor.sv ====
// Purpose: port checks beside drc_top
// Assumes: stimulus changes just after rising mclk
// Notes:   pin commands are seen raw, before the block's sync latency
`timescale 1ns/10ps
`include "drc_map.vh"
module drc_monitor (
  input wire        mclk,
  input wire        srst,
  input wire        cke_pin,
  input wire        cs_n_pin,
  input wire        ras_n_pin,
  input wire        cas_n_pin,
  input wire        we_n_pin,
  input wire [2:0]  ba_pin,
  input wire [15:0] addr_pin,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        sref_active_r,
  input wire        dll_off_r,
  input wire        ref_busy_r,
  input wire        rd_win_start_r
);
  // ------------------------------------------------------------
  // decode and properties
  // ------------------------------------------------------------
  wire [2:0] op  = {ras_n_pin, cas_n_pin, we_n_pin};
  wire       sel = !cs_n_pin;
  wire       acc = psel && penable && !pready;
  wire       hit = paddr[11:5] == 7'h00 && paddr[4:0] <= 5'h10 && paddr[1:0] == 2'h0;
  wire       mr1 = sel && cke_pin && op == `DRC_CMD_MRS && ba_pin == 3'h1;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  property p_rst; disable iff (1'b0) srst |=> !pready && !ref_busy_r && !dll_off_r; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_ref_go; sel && cke_pin && $past(cke_pin) && op == `DRC_CMD_REF && !ref_busy_r
    && !sref_active_r |-> ##[2:4] ref_busy_r; endproperty
  a_ref_go: assert property (p_ref_go) else $error("refresh window did not open");
  property p_acc; acc |=> pready; endproperty
  a_acc: assert property (p_acc) else $error("no answer one cycle after access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held past one cycle");
  property p_unmap; acc && !hit && !pwrite |=> pslverr && prdata == 32'h00000000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_dll_off; mr1 && $past(cke_pin) && addr_pin[0] |-> ##[1:4] dll_off_r; endproperty
  a_dll_off: assert property (p_dll_off) else $error("dll off not seen");
  property p_dll_on; mr1 && $past(cke_pin) && !addr_pin[0] |-> ##[1:4] !dll_off_r; endproperty
  a_dll_on: assert property (p_dll_on) else $error("dll on not seen");
  property p_sref; sel && !cke_pin && $past(cke_pin) && op == `DRC_CMD_REF
    |-> ##[1:4] sref_active_r; endproperty
  a_sref: assert property (p_sref) else $error("self refresh not entered");
  property p_rdw; rd_win_start_r |=> !rd_win_start_r; endproperty
  a_rdw: assert property (p_rdw) else $error("strobe window start not a pulse");
  c_ref: cover property ($rose(ref_busy_r));
  c_sref: cover property ($rose(sref_active_r));
  c_rd_off: cover property (rd_win_start_r && dll_off_r);
endmodule
bind drc_top drc_monitor u_drc_monitor (
  .mclk(mclk), .srst(srst), .cke_pin(cke_pin), .cs_n_pin(cs_n_pin), .ras_n_pin(ras_n_pin),
  .cas_n_pin(cas_n_pin), .we_n_pin(we_n_pin), .ba_pin(ba_pin), .addr_pin(addr_pin),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sref_active_r(sref_active_r), .dll_off_r(dll_off_r),
  .ref_busy_r(ref_busy_r), .rd_win_start_r(rd_win_start_r)
);

// ==== sim/drc_ctl_model.sv ====
// Purpose: memory controller stand-in on the ddr3 command pins
// Assumes: one caller at a time
// Notes: odt never rises and no write is issued, so vref timing holds
`timescale 1ns/10ps
`include "drc_map.vh"
module drc_ctl_model (
  input  wire        mclk,
  output reg         cke,
  output reg         cs_n,
  output reg         ras_n,
  output reg         cas_n,
  output reg         we_n,
  output reg  [2:0]  ba,
  output reg  [15:0] addr,
  output reg         odt
);
  // ------------------------------------------------------------
  // command driver
  // ------------------------------------------------------------
  // start idle with cke high termination kept off
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = 3'h0;
    addr = 16'h0000;
    odt = 1'b0;
  end
  // one command cycle, then deselect with inverted address so stale values never match
  task cmd(input [2:0] c, input [2:0] b, input [15:0] a, input k);
    begin
      @(posedge mclk);
      cke <= k;
      cs_n <= 1'b0;
      {ras_n, cas_n, we_n} <= c;
      ba <= b;
      addr <= a;
      @(posedge mclk);
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= 3'h7;
      ba <= ~b;
      addr <= ~a;
    end
  endtask
  task set_cke(input k);
    begin
      @(posedge mclk);
      cke <= k;
    end
  endtask
  // all banks closed with a10 high before each refresh
  task refresh(input [15:0] a);
    begin
      cmd(`DRC_CMD_PRE, 3'h0, 16'h0400, 1'b1);
      cmd(`DRC_CMD_REF, 3'h7, a, 1'b1);
    end
  endtask
endmodule

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for drc_top
// Assumes: pins come from drc_ctl_model, apb from this bench
// Notes:   trfc reprogrammed short; mode waits use one small count
`timescale 1ns/10ps
`include "drc_map.vh"
module tb_top;
  localparam integer T_TRFC = 8;
  localparam integer T_WAIT = 16; // stands in for tmod, tmrd, txs
  reg         mclk = 1'b0;
  reg         srst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h00000000;
  reg  [31:0] rd;
  reg         er;
  wire        cke, cs_n, ras_n, cas_n, we_n, odt;
  wire [2:0]  ba;
  wire [15:0] addr;
  wire [31:0] prdata;
  wire        pready, pslverr, sref_active_r, dll_off_r, ref_busy_r, rd_win_start_r;
  integer     bad_count = 0;
  integer     n_compared = 0;
  integer     d_on, d_off, n, c0;
  always #2 mclk = ~mclk;
  drc_ctl_model u_drc_ctl_model (.mclk(mclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt));
  drc_top u_drc_top (.mclk(mclk), .srst(srst), .cke_pin(cke), .cs_n_pin(cs_n),
    .ras_n_pin(ras_n), .cas_n_pin(cas_n), .we_n_pin(we_n), .ba_pin(ba), .addr_pin(addr),
    .odt_pin(odt), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sref_active_r(sref_active_r), .dll_off_r(dll_off_r), .ref_busy_r(ref_busy_r),
    .rd_win_start_r(rd_win_start_r));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // request held until pready is seen high at a rising edge
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // waits out the whole trfc window before returning, so no command lands inside it
  task busy_len(output integer k);
    integer g;
    begin
      g = 0;
      k = 0;
      while (ref_busy_r !== 1'b1 && g < 20) begin
        @(posedge mclk);
        g = g + 1;
      end
      while (ref_busy_r === 1'b1 && k < 400) begin
        @(posedge mclk);
        k = k + 1;
      end
    end
  endtask
  task rd_delay(output integer k);
    begin
      u_drc_ctl_model.cmd(`DRC_CMD_ACT, 3'h0, 16'h0012, 1'b1);
      u_drc_ctl_model.cmd(`DRC_CMD_RD, 3'h0, 16'h0000, 1'b1);
      k = 0;
      while (rd_win_start_r !== 1'b1 && k < 40) begin
        @(posedge mclk);
        k = k + 1;
      end
      u_drc_ctl_model.cmd(`DRC_CMD_PRE, 3'h0, 16'h0400, 1'b1); // back to idle
    end
  endtask
  // txs is waited out before any command
  task sref_cycle;
    begin
      u_drc_ctl_model.cmd(`DRC_CMD_REF, 3'h0, 16'h0000, 1'b0);
      repeat (T_WAIT) @(posedge mclk);
      chk(sref_active_r, 32'h1);
      u_drc_ctl_model.set_cke(1'b1);
      repeat (T_WAIT) @(posedge mclk);
      chk(sref_active_r, 32'h0);
    end
  endtask
  task tally_and_finish;
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_regs;
    begin
      apb(1'b0, `DRC_OFF_CTRL, 32'h0);
      chk(rd, 32'h00000060);
      apb(1'b0, `DRC_OFF_TRFC, 32'h0);
      chk(rd, 32'h0000006e);
      apb(1'b1, `DRC_OFF_TRFC, 32'h0);
      apb(1'b0, `DRC_OFF_TRFC, 32'h0);
      chk(rd, 32'h00000001);
      apb(1'b0, 12'h014, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      apb(1'b1, `DRC_OFF_TRFC, T_TRFC);
      $display("regs test done");
    end
  endtask
  task t_refresh;
    begin
      apb(1'b0, `DRC_OFF_REFCNT, 32'h0);
      c0 = rd;
      // refreshes come far inside the average interval, none postponed
      u_drc_ctl_model.refresh(16'hffff); // address pins must not matter
      busy_len(n);
      chk(n, T_TRFC);
      u_drc_ctl_model.cmd(`DRC_CMD_REF, 3'h2, 16'h1234, 1'b1);
      busy_len(n);
      chk(n, T_TRFC);
      apb(1'b0, `DRC_OFF_REFCNT, 32'h0);
      chk(rd, c0 + 2);
      apb(1'b0, `DRC_OFF_STATUS, 32'h0);
      chk(rd & 32'h38, 32'h0);
      u_drc_ctl_model.refresh(16'h0000);
      u_drc_ctl_model.cmd(`DRC_CMD_ACT, 3'h0, 16'h0000, 1'b1);
      busy_len(n);
      apb(1'b0, `DRC_OFF_STATUS, 32'h0);
      chk(rd & 32'h08, 32'h08);
      apb(1'b1, `DRC_OFF_STATUS, 32'h08);
      apb(1'b0, `DRC_OFF_STATUS, 32'h0);
      chk(rd & 32'h08, 32'h0);
      $display("refresh test done");
    end
  endtask
  task t_dll;
    begin
      rd_delay(d_on);
      u_drc_ctl_model.cmd(`DRC_CMD_MRS, 3'h1, 16'h0001, 1'b1); // rtt fields zero
      repeat (T_WAIT) @(posedge mclk);
      chk(dll_off_r, 32'h1);
      sref_cycle; // rate change would sit inside here
      rd_delay(d_off);
      chk(d_on - d_off, 32'h1);
      apb(1'b0, `DRC_OFF_STATUS, 32'h0);
      chk(rd & 32'h3e, 32'h02);
      apb(1'b1, `DRC_OFF_CTRL, 32'h70);
      apb(1'b0, `DRC_OFF_STATUS, 32'h0);
      chk(rd & 32'h20, 32'h20);
      apb(1'b1, `DRC_OFF_CTRL, 32'h60);
      apb(1'b1, `DRC_OFF_STATUS, 32'h20);
      apb(1'b0, `DRC_OFF_STATUS, 32'h0);
      chk(rd & 32'h20, 32'h0);
      sref_cycle;
      u_drc_ctl_model.cmd(`DRC_CMD_MRS, 3'h1, 16'h0000, 1'b1);
      repeat (T_WAIT) @(posedge mclk);
      chk(dll_off_r, 32'h0);
      u_drc_ctl_model.cmd(`DRC_CMD_MRS, 3'h0, 16'h0100, 1'b1);
      repeat (T_WAIT * 4) @(posedge mclk); // lock time before a timed read
      rd_delay(n);
      chk(n, d_on);
      $display("dll test done");
    end
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    t_regs;
    t_refresh;
    t_dll;
    tally_and_finish;
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    bad_count = bad_count + 1;
    tally_and_finish;
  end
endmodule
